// ==== verilog/pbxh_pkg.sv ====
package pbxh_pkg;
	// software-facing register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_HDLC     = 8'h04;
	localparam logic [7:0] REG_ADDR     = 8'h08;
	localparam logic [7:0] REG_ARB      = 8'h0c;
	localparam logic [7:0] REG_OPT      = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;
	localparam int         NUM_CFG      = 5;
	localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
	// control register fields
	localparam int CTRL_START    = 0;
	localparam int CTRL_TS_LOWZ  = 1;
	localparam int CTRL_PCM_REL  = 2;
	localparam int CTRL_HWY_REL  = 3;
	localparam int CTRL_DRV_OD   = 4;
	localparam int CTRL_AUTO     = 5;
	localparam int CTRL_ONE_BYTE = 6;
	localparam int CTRL_BUS_CFG  = 7;
	// status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_SYNC = 2;
	// device register addresses on its parallel port
	localparam logic [7:0] DEV_OPERATION_MODE_REG = 8'h00;
	localparam logic [7:0] DEV_MDAT = 8'h01;
	localparam logic [7:0] DEV_MCTL = 8'h02;
	localparam logic [7:0] DEV_STAT = 8'h03;
	localparam logic [7:0] DEV_MODE = 8'h20;
	localparam logic [7:0] DEV_RECV_ADDR_HIGH_1 = 8'h21;
	localparam logic [7:0] DEV_RECV_ADDR_HIGH_2 = 8'h22;
	localparam logic [7:0] DEV_RECV_ADDR_LOW_1 = 8'h23;
	localparam logic [7:0] DEV_RECV_ADDR_LOW_2 = 8'h24;
	localparam logic [7:0] DEV_XMIT_ADDR_1 = 8'h25;
	localparam logic [7:0] DEV_XMIT_ADDR_2 = 8'h26;
	localparam logic [7:0] DEV_CFG2 = 8'h27;
	localparam logic [7:0] DEV_CFG1 = 8'h28;
	localparam logic [7:0] DEV_MASK = 8'h29;
	localparam logic [7:0] DEV_RLEN = 8'h2a;
	localparam logic [7:0] DEV_CMD  = 8'h2b;
	localparam logic [7:0] DEV_XDST = 8'h30;
	localparam logic [7:0] DEV_AMOD = 8'h31;
	localparam logic [7:0] DEV_CHEN = 8'h32;
	// device register values and field positions
	localparam logic [7:0] OPERATION_MODE_REG_NORMAL   = 8'hc0;
	localparam int         OPERATION_MODE_REG_PSB      = 5;
	localparam int         OPERATION_MODE_REG_COS      = 3;
	localparam int         OPERATION_MODE_REG_MONITOR_HANDSHAKE_SELECT     = 2;
	localparam int         OPERATION_MODE_REG_CSB      = 1;
	localparam logic [7:0] MOC_TS_ALL    = 8'h68;
	localparam logic [7:0] TS_ALL_HIGHZ  = 8'h00;
	localparam logic [7:0] TS_ALL_LOWZ   = 8'h0f;
	localparam logic [7:0] CMD_TXRX_RST  = 8'hc1;
	localparam int         STATUS_REG_BUSY_BIT = 6;
	localparam int         STATUS_REG_SYNC_BIT = 5;
	// timing
	localparam logic [10:0] RCL_BULK_CYC = 11'd1035;
	localparam int CLK_NS        = 10;
	localparam int STROBE_NS     = 80;
	localparam int GAP_NS        = 40;
	localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] GAP_CYC    = 4'((GAP_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_ISSUE = 4'b0010,
		S_WAIT  = 4'b0100,
		S_RCL   = 4'b1000
	} pbxh_state_e;
	typedef enum logic [2:0] {
		E_IDLE = 3'b001,
		E_STRB = 3'b010,
		E_GAP  = 3'b100
	} pbxh_eng_e;
	typedef enum logic [2:0] {K_WR, K_RD, K_POLL, K_RCL, K_SKIP, K_END} pbxh_kind_e;
	typedef struct packed {
		pbxh_kind_e kind;
		logic [7:0] addr;
		logic [7:0] data;
	} pbxh_step_s;
endpackage

// ==== verilog/pbxh_dbus_if.sv ====
interface pbxh_dbus_if;
	logic       req;
	logic       is_rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       done;
	logic [7:0] rdata;
	modport ctrl   (output req, is_rd, addr, wdata, input done, rdata);
	modport engine (input req, is_rd, addr, wdata, output done, rdata);
endinterface

// ==== verilog/pbxh_dbus_engine.sv ====
module pbxh_dbus_engine
	import pbxh_pkg::*;
(
	input  wire logic       mclk,         // system clock
	input  wire logic       rst_n,        // synchronised reset
	pbxh_dbus_if.engine     bus,          // access requests
	output logic [7:0]      dev_addr,     // device address
	output logic            dev_cs_n,     // chip select
	output logic            dev_rd_n,     // read strobe
	output logic            dev_wr_n,     // write strobe
	output logic [7:0]      dev_wdata,    // data driven to device
	output logic            dev_wdata_en, // data driver enable
	input  wire logic [7:0] dev_rdata     // data from device pins
);
	pbxh_eng_e  st_q;
	logic [3:0] cnt_q;
	logic [7:0] din_s1_q;
	logic [7:0] din_s2_q;

	// pins are asynchronous to mclk; strobe is long enough to cover the sync delay
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			din_s1_q <= 8'h00;
			din_s2_q <= 8'h00;
		end
		else
		begin
			din_s1_q <= dev_rdata;
			din_s2_q <= din_s1_q;
		end

	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			st_q         <= E_IDLE;
			cnt_q        <= 4'h0;
			dev_addr     <= 8'h00;
			dev_cs_n     <= 1'b1;
			dev_rd_n     <= 1'b1;
			dev_wr_n     <= 1'b1;
			dev_wdata    <= 8'h00;
			dev_wdata_en <= 1'b0;
			bus.done     <= 1'b0;
			bus.rdata    <= 8'h00;
		end
		else
		begin
			bus.done <= 1'b0;
			case (st_q)
				E_IDLE:
					if (bus.req)
					begin
						st_q         <= E_STRB;
						cnt_q        <= 4'h1;
						dev_addr     <= bus.addr;
						dev_cs_n     <= 1'b0;
						dev_rd_n     <= !bus.is_rd;
						dev_wr_n     <= bus.is_rd;
						dev_wdata    <= bus.wdata;
						dev_wdata_en <= !bus.is_rd;
					end
				E_STRB:
					if (cnt_q == STROBE_CYC)
					begin
						st_q      <= E_GAP;
						cnt_q     <= 4'h1;
						dev_cs_n  <= 1'b1;
						dev_rd_n  <= 1'b1;
						dev_wr_n  <= 1'b1;
						bus.rdata <= din_s2_q;
					end
					else
						cnt_q <= cnt_q + 4'h1;
				E_GAP:
					// data held one extra recovery period after the strobe ends
					if (cnt_q == GAP_CYC)
					begin
						st_q         <= E_IDLE;
						dev_wdata_en <= 1'b0;
						bus.done     <= 1'b1;
					end
					else
						cnt_q <= cnt_q + 4'h1;
				default:
					st_q <= E_IDLE;
			endcase
		end

	property p_strobe_width;
		@(posedge mclk) disable iff (!rst_n)
		$fell(dev_cs_n) |-> (!dev_cs_n)[*8] ##1 dev_cs_n;
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
endmodule

// ==== verilog/pbxh_init_ctrl.sv ====
// Summary of operation
// - bulk load 1035 reference cycles; wait busy clear
// - write hdlc mode register first, receiver active
// - write address registers per mode, high zero; in one-byte auto mode the second high byte is written from REG_ADDR instead
// - second channel config written next
// - collision input tied low point-to-point
// - optional registers written before power-up
// - first channel config written last, powers up
// - after power-up issue transmitter/receiver reset
// - arbiter configured after switch and hdlc parts
// - monitor-bit blocking uses 11xxxx01 even data
// - command-code blocking activates with 1100
// - arbiter mode and channel enables enable reception
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
module pbxh_init_ctrl
	import pbxh_pkg::*;
(
	input  wire logic        mclk,            // system clock, 100 MHz
	input  wire logic        resetn,          // asynchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,    // write address
	input  wire logic        s_axi_awvalid,   // write address valid
	output logic             s_axi_awready,   // write address ready
	input  wire logic [31:0] s_axi_wdata,     // write data
	input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
	input  wire logic        s_axi_wvalid,    // write data valid
	output logic             s_axi_wready,    // write data ready
	output logic [1:0]       s_axi_bresp,     // write response
	output logic             s_axi_bvalid,    // write response valid
	input  wire logic        s_axi_bready,    // write response ready
	input  wire logic [7:0]  s_axi_araddr,    // read address
	input  wire logic        s_axi_arvalid,   // read address valid
	output logic             s_axi_arready,   // read address ready
	output logic [31:0]      s_axi_rdata,     // read data
	output logic [1:0]       s_axi_rresp,     // read response
	output logic             s_axi_rvalid,    // read data valid
	input  wire logic        s_axi_rready,    // read data ready
	input  wire logic        reference_clock, // highway reference clock pin
	output logic [7:0]       dev_addr,        // device address
	output logic             dev_cs_n,        // device chip select
	output logic             dev_rd_n,        // device read strobe
	output logic             dev_wr_n,        // device write strobe
	output logic [7:0]       dev_wdata,       // device data out
	output logic             dev_wdata_en,    // device data drive enable
	input  wire logic [7:0]  dev_rdata,       // device data in
	output logic             col_det_low      // hold collision input low
);
	logic        rst_s1_q;
	logic        rst_n;
	logic [31:0] regs_q [NUM_CFG];
	logic        aw_got_q;
	logic        w_got_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [2:0]  widx;
	logic        wmap;
	logic [2:0]  ridx;
	logic        start_q;
	pbxh_state_e state_q;
	logic [4:0]  step_q;
	pbxh_step_s  cur;
	logic        done_q;
	logic [7:0]  status_reg_q;
	logic        rcl_s1_q;
	logic        rcl_s2_q;
	logic        rcl_s3_q;
	logic        rcl_rise;
	logic [10:0] rcl_cnt_q;
	logic        seen_mode_q;
	logic        seen_cfg2_q;
	logic        seen_cfg1_q;
	logic        iss_wr;
	logic [7:0]  operation_mode_reg_final;
	logic [31:0] ctrl;
	logic [31:0] status;

	pbxh_dbus_if bus ();

	pbxh_dbus_engine u_engine (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.bus          (bus.engine),
		.dev_addr     (dev_addr),
		.dev_cs_n     (dev_cs_n),
		.dev_rd_n     (dev_rd_n),
		.dev_wr_n     (dev_wr_n),
		.dev_wdata    (dev_wdata),
		.dev_wdata_en (dev_wdata_en),
		.dev_rdata    (dev_rdata)
	);

	// release of reset is synchronised; assertion stays asynchronous
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
		begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end

	assign ctrl = regs_q[0];
	assign widx = awaddr_q[4:2];
	assign wmap = (awaddr_q[7:5] == 3'h0) && (widx < 3'(NUM_CFG));
	assign ridx = s_axi_araddr[4:2];
	assign status = {11'h000, step_q, status_reg_q, 5'h00, status_reg_q[STATUS_REG_SYNC_BIT], done_q,
		state_q != S_IDLE};

	// axi write channel: address and data may arrive in either order
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			start_q       <= 1'b0;
			for (int i = 0; i < NUM_CFG; i++)
				regs_q[i] <= CFG_RESET;
		end
		else
		begin
			start_q       <= 1'b0;
			s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_got_q && !s_axi_bvalid;
			s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !w_got_q && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid)
			begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wmap || awaddr_q == REG_STATUS) ? 2'b00 : 2'b10;
				if (wmap)
					for (int b = 0; b < 4; b++)
						if (wstrb_q[b])
							regs_q[widx][b*8 +: 8] <= wdata_q[b*8 +: 8];
				// a start while a sequence runs is dropped, not queued
				if (wmap && widx == 3'h0 && wstrb_q[0] && wdata_q[CTRL_START])
					start_q <= (state_q == S_IDLE);
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end

	// axi read channel
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				if (s_axi_araddr[7:5] != 3'h0 || s_axi_araddr[1:0] != 2'b00)
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
				else if (ridx == 3'h0)
					s_axi_rdata <= {ctrl[31:1], 1'b0};
				else if (ridx < 3'(NUM_CFG))
					s_axi_rdata <= regs_q[ridx];
				else if (s_axi_araddr == REG_STATUS)
					s_axi_rdata <= status;
				else
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end

	// reference clock is only sampled; its edges pace the bulk-load wait
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			rcl_s1_q <= 1'b0;
			rcl_s2_q <= 1'b0;
			rcl_s3_q <= 1'b0;
		end
		else
		begin
			rcl_s1_q <= reference_clock;
			rcl_s2_q <= rcl_s1_q;
			rcl_s3_q <= rcl_s2_q;
		end
	assign rcl_rise = rcl_s2_q && !rcl_s3_q;

	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			rcl_cnt_q <= 11'h000;
		else if (state_q != S_RCL)
			rcl_cnt_q <= 11'h000;
		else if (rcl_rise && rcl_cnt_q != RCL_BULK_CYC)
			rcl_cnt_q <= rcl_cnt_q + 11'h001;

	// pcm drivers stay floating until the very last mode write
	assign operation_mode_reg_final = OPERATION_MODE_REG_NORMAL
		| (ctrl[CTRL_PCM_REL] ? 8'(1 << OPERATION_MODE_REG_PSB) : 8'h00)
		| (ctrl[CTRL_DRV_OD] ? 8'(1 << OPERATION_MODE_REG_COS) : 8'h00)
		| 8'(1 << OPERATION_MODE_REG_MONITOR_HANDSHAKE_SELECT)
		| (ctrl[CTRL_HWY_REL] ? 8'(1 << OPERATION_MODE_REG_CSB) : 8'h00);

	// access sequence
	always_comb
	begin
		cur = '{K_END, 8'h00, 8'h00};
		case (step_q)
			5'd0:  cur = '{K_WR, DEV_OPERATION_MODE_REG, OPERATION_MODE_REG_NORMAL};
			5'd1:  cur = '{K_WR, DEV_MDAT, ctrl[CTRL_TS_LOWZ] ? TS_ALL_LOWZ : TS_ALL_HIGHZ};
			5'd2:  cur = '{K_WR, DEV_MCTL, MOC_TS_ALL};
			5'd3:  cur = '{K_RCL, 8'h00, 8'h00};
			5'd4:  cur = '{K_POLL, DEV_STAT, 8'h00};
			5'd5:  cur = '{K_WR, DEV_MODE, regs_q[1][7:0]};
			5'd6:  cur = '{K_WR, DEV_RECV_ADDR_HIGH_1, ctrl[CTRL_ONE_BYTE] ? 8'h00 : regs_q[2][7:0]};
			5'd7:  cur = '{K_WR, DEV_RECV_ADDR_HIGH_2, (ctrl[CTRL_ONE_BYTE] && !ctrl[CTRL_AUTO])
				? 8'h00 : regs_q[2][15:8]};
			5'd8:  cur = '{K_WR, DEV_RECV_ADDR_LOW_1, regs_q[2][23:16]};
			5'd9:  cur = '{K_WR, DEV_RECV_ADDR_LOW_2, regs_q[2][31:24]};
			5'd10: cur = '{ctrl[CTRL_AUTO] ? K_WR : K_SKIP, DEV_XMIT_ADDR_1, ctrl[23:16]};
			5'd11: cur = '{ctrl[CTRL_AUTO] ? K_WR : K_SKIP, DEV_XMIT_ADDR_2, ctrl[31:24]};
			5'd12: cur = '{K_WR, DEV_CFG2, regs_q[1][15:8]};
			5'd13: cur = '{K_WR, DEV_MASK, regs_q[1][31:24]};
			5'd14: cur = '{K_WR, DEV_RLEN, regs_q[4][7:0]};
			5'd15: cur = '{K_WR, DEV_CFG1, regs_q[1][23:16]};
			5'd16: cur = '{K_WR, DEV_CMD, CMD_TXRX_RST};
			5'd17: cur = '{K_WR, DEV_XDST, regs_q[3][7:0]};
			5'd18: cur = '{K_WR, DEV_AMOD, regs_q[3][15:8]};
			5'd19: cur = '{K_WR, DEV_CHEN, regs_q[3][23:16]};
			5'd20: cur = '{K_WR, DEV_OPERATION_MODE_REG, operation_mode_reg_final};
			5'd21: cur = '{K_RD, DEV_STAT, 8'h00};
			default: cur = '{K_END, 8'h00, 8'h00};
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			state_q   <= S_IDLE;
			step_q    <= 5'd0;
			done_q    <= 1'b0;
			status_reg_q    <= 8'h00;
			bus.req   <= 1'b0;
			bus.is_rd <= 1'b0;
			bus.addr  <= 8'h00;
			bus.wdata <= 8'h00;
		end
		else
		begin
			bus.req <= 1'b0;
			case (state_q)
				S_IDLE:
					if (start_q)
					begin
						state_q <= S_ISSUE;
						step_q  <= 5'd0;
						done_q  <= 1'b0;
					end
				S_ISSUE:
					case (cur.kind)
						K_WR, K_RD, K_POLL:
						begin
							bus.req   <= 1'b1;
							bus.is_rd <= (cur.kind != K_WR);
							bus.addr  <= cur.addr;
							bus.wdata <= cur.data;
							state_q   <= S_WAIT;
						end
						K_RCL:
							state_q <= S_RCL;
						K_SKIP:
							step_q <= step_q + 5'd1;
						default:
						begin
							state_q <= S_IDLE;
							done_q  <= 1'b1;
						end
					endcase
				S_WAIT:
					if (bus.done)
					begin
						state_q <= S_ISSUE;
						if (cur.kind == K_RD)
							status_reg_q <= bus.rdata;
						// keep polling while the bulk operation is running
						if (!(cur.kind == K_POLL && bus.rdata[STATUS_REG_BUSY_BIT]))
							step_q <= step_q + 5'd1;
					end
				S_RCL:
					if (rcl_cnt_q == RCL_BULK_CYC)
					begin
						state_q <= S_ISSUE;
						step_q  <= step_q + 5'd1;
					end
				default:
					state_q <= S_IDLE;
			endcase
		end

	// point-to-point without modem clear-to-send needs the input grounded
	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
			col_det_low <= 1'b1;
		else
			col_det_low <= !ctrl[CTRL_BUS_CFG];

	assign iss_wr = (state_q == S_ISSUE) && (cur.kind == K_WR);

	always_ff @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			seen_mode_q <= 1'b0;
			seen_cfg2_q <= 1'b0;
			seen_cfg1_q <= 1'b0;
		end
		else if (start_q)
		begin
			seen_mode_q <= 1'b0;
			seen_cfg2_q <= 1'b0;
			seen_cfg1_q <= 1'b0;
		end
		else if (iss_wr)
		begin
			seen_mode_q <= seen_mode_q || cur.addr == DEV_MODE;
			seen_cfg2_q <= seen_cfg2_q || cur.addr == DEV_CFG2;
			seen_cfg1_q <= seen_cfg1_q || cur.addr == DEV_CFG1;
		end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_rcl_wait;
		(state_q == S_RCL && rcl_cnt_q < RCL_BULK_CYC) |=> state_q == S_RCL;
	endproperty
	a_rcl_wait: assert property (p_rcl_wait) else $error("bulk wait ended early");

	property p_poll_hold;
		(state_q == S_WAIT && bus.done && cur.kind == K_POLL && bus.rdata[STATUS_REG_BUSY_BIT])
			|=> state_q == S_ISSUE && step_q == $past(step_q);
	endproperty
	a_poll_hold: assert property (p_poll_hold) else $error("moved on while busy");

	property p_ts_value;
		(iss_wr && cur.addr == DEV_MDAT) |=> bus.req
			&& bus.wdata == (ctrl[CTRL_TS_LOWZ] ? TS_ALL_LOWZ : TS_ALL_HIGHZ);
	endproperty
	a_ts_value: assert property (p_ts_value) else $error("wrong timeslot fill");

	property p_psb_low;
		(iss_wr && cur.addr == DEV_OPERATION_MODE_REG && !seen_cfg1_q) |-> !cur.data[OPERATION_MODE_REG_PSB];
	endproperty
	a_psb_low: assert property (p_psb_low) else $error("pcm released early");

	property p_mode_first;
		(iss_wr && cur.addr[7:4] == 4'h2 && cur.addr != DEV_MODE) |-> seen_mode_q;
	endproperty
	a_mode_first: assert property (p_mode_first) else $error("mode not first");

	property p_onebyte;
		(iss_wr && cur.addr == DEV_RECV_ADDR_HIGH_1 && ctrl[CTRL_ONE_BYTE]) |=> bus.wdata == 8'h00;
	endproperty
	a_onebyte: assert property (p_onebyte) else $error("high address not zero");

	property p_cfg1_last;
		(iss_wr && cur.addr == DEV_CFG1) |-> seen_cfg2_q;
	endproperty
	a_cfg1_last: assert property (p_cfg1_last) else $error("config 1 before 2");

	property p_cmd_reset;
		(iss_wr && cur.addr == DEV_CMD) |-> seen_cfg1_q && cur.data == CMD_TXRX_RST;
	endproperty
	a_cmd_reset: assert property (p_cmd_reset) else $error("reset before power-up");

	property p_arb_after;
		(iss_wr && cur.addr[7:4] == 4'h3) |-> seen_cfg1_q && seen_mode_q;
	endproperty
	a_arb_after: assert property (p_arb_after) else $error("arbiter set too early");
endmodule

// ==== dv/pbxh_dev_model.sv ====
module pbxh_dev_model
	import pbxh_pkg::*;
(
	input  wire logic       mclk,            // sampling clock
	input  wire logic       resetn,          // device reset, active low
	input  wire logic       reference_clock, // reference clock pin
	input  wire logic [7:0] dev_addr,        // register address
	input  wire logic       dev_cs_n,        // chip select
	input  wire logic       dev_rd_n,        // read strobe
	input  wire logic       dev_wr_n,        // write strobe
	input  wire logic [7:0] dev_wdata,       // data from controller
	output logic [7:0]      dev_rdata        // data to controller
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0]  regs [256];
	logic [3:0]  ts_field [32];
	logic [10:0] busy_cnt;
	logic [2:0]  ref_s = 3'h0;
	logic        pend, rd_q, rise, sel;
	logic [7:0]  wa, wd, last, stat;
	logic [3:0]  pcm_lowz;
	int          ref_cnt = 0;
	int          n_stat = 0;
	logic [7:0]  log_a [$];
	logic [7:0]  log_d [$];
	int          log_r [$];
	always_comb
	begin
		stat = 8'h00;
		stat[STATUS_REG_BUSY_BIT] = busy_cnt != 11'h000;
		stat[STATUS_REG_SYNC_BIT] = regs[DEV_OPERATION_MODE_REG][7:6] == 2'b11;
	end
	assign rise = ref_s[1] && !ref_s[2];
	assign sel = !dev_cs_n && !dev_rd_n;
	// a released data bus toggles so a late sample cannot pass by luck
	assign dev_rdata = sel ? ((dev_addr == DEV_STAT) ? stat : regs[dev_addr]) : ~last;
	assign pcm_lowz = regs[DEV_OPERATION_MODE_REG][OPERATION_MODE_REG_PSB] ? ts_field[0] : 4'h0;
	// the tri-state field has no reset branch: it survives reset
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_cnt <= 11'h000;
			pend <= 1'b0;
			rd_q <= 1'b1;
			last <= 8'h00;
			for (int i = 0; i < 256; i++)
				regs[i] <= 8'h00;
		end
		else
		begin
			ref_s <= {ref_s[1:0], reference_clock};
			rd_q <= dev_rd_n;
			last <= dev_rdata;
			if (rise)
				ref_cnt++;
			if (rise && busy_cnt != 11'h000)
				busy_cnt <= busy_cnt - 11'h001;
			if (sel && rd_q && dev_addr == DEV_STAT)
				n_stat++;
			if (!dev_cs_n && !dev_wr_n)
			begin
				wa <= dev_addr;
				wd <= dev_wdata;
				pend <= 1'b1;
			end
			else if (pend)
			begin
				pend <= 1'b0;
				log_a.push_back(wa);
				log_d.push_back(wd);
				log_r.push_back(ref_cnt);
				if (wa == DEV_MCTL && wd == MOC_TS_ALL && stat == 8'h20)
				begin
					busy_cnt <= RCL_BULK_CYC;
					for (int i = 0; i < 32; i++)
						ts_field[i] <= regs[DEV_MDAT][3:0];
				end
				else if (busy_cnt == 11'h000 || (wa != DEV_MCTL && wa != DEV_MDAT))
					regs[wa] <= wd;
			end
		end
	end
endmodule

// ==== dv/tb_pbxh_init_ctrl.sv ====
module tb_pbxh_init_ctrl
	import pbxh_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] HD = 32'h3c87_00a8;
	localparam logic [31:0] AD = 32'h4433_4011;
	localparam logic [31:0] AB = 32'h0001_f900;
	localparam logic [31:0] OP = 32'h0000_007f;
	logic        mclk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, ref_clk, cs_n, rd_n, wr_n, wen, cdl;
	logic [7:0]  awaddr, araddr, dadr, dwd, drd;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [31:0] v;
	logic [1:0]  r;
	int          n_fail = 0;
	int          check_count = 0;
	pbxh_init_ctrl i_pbxh_init_ctrl (.mclk(mclk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .reference_clock(ref_clk), .dev_addr(dadr), .dev_cs_n(cs_n),
		.dev_rd_n(rd_n), .dev_wr_n(wr_n), .dev_wdata(dwd), .dev_wdata_en(wen),
		.dev_rdata(drd), .col_det_low(cdl));
	pbxh_dev_model i_pbxh_dev_model (.mclk(mclk), .resetn(resetn), .reference_clock(ref_clk),
		.dev_addr(dadr), .dev_cs_n(cs_n), .dev_rd_n(rd_n), .dev_wr_n(wr_n), .dev_wdata(dwd),
		.dev_rdata(drd));
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		check_count++;
		if (s !== e)
		begin
			n_fail++;
			$display("ERROR %0t %s: seen %h expected %h", $time, m, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge mclk);
			if (!aw && awready === 1'b1)
			begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge mclk);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge mclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge mclk);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic cfg;
		axi_rd(REG_HDLC);
		chk(v, CFG_RESET, "hdlc reset value");
		axi_wr(REG_HDLC, HD);
		axi_wr(REG_ADDR, AD);
		axi_wr(REG_ARB, AB);
		axi_wr(REG_OPT, OP);
		axi_rd(REG_ARB);
		chk(v, AB, "arb readback");
	endtask
	task automatic run(input logic [31:0] c);
		logic [7:0] ea [$];
		logic [7:0] ed [$];
		int s0;
		s0 = i_pbxh_dev_model.n_stat;
		i_pbxh_dev_model.log_a.delete();
		i_pbxh_dev_model.log_d.delete();
		i_pbxh_dev_model.log_r.delete();
		axi_wr(REG_CTRL, c);
		axi_rd(REG_STATUS);
		chk(v[ST_BUSY], 1'b1, "busy after start");
		axi_wr(REG_CTRL, c); // start again while busy must be ignored
		while (v[ST_DONE] !== 1'b1)
			axi_rd(REG_STATUS);
		chk(v[15:0], 16'h2006, "final status");
		ea = '{DEV_OPERATION_MODE_REG, DEV_MDAT, DEV_MCTL, DEV_MODE, DEV_RECV_ADDR_HIGH_1, DEV_RECV_ADDR_HIGH_2, DEV_RECV_ADDR_LOW_1, DEV_RECV_ADDR_LOW_2};
		ed = '{OPERATION_MODE_REG_NORMAL, c[1] ? TS_ALL_LOWZ : TS_ALL_HIGHZ, MOC_TS_ALL, HD[7:0],
			c[6] ? 8'h00 : AD[7:0], (c[6] && !c[5]) ? 8'h00 : AD[15:8], AD[23:16], AD[31:24]};
		if (c[5])
		begin
			ea = {ea, DEV_XMIT_ADDR_1, DEV_XMIT_ADDR_2};
			ed = {ed, c[23:16], c[31:24]};
		end
		ea = {ea, DEV_CFG2, DEV_MASK, DEV_RLEN, DEV_CFG1, DEV_CMD, DEV_XDST, DEV_AMOD, DEV_CHEN};
		ed = {ed, HD[15:8], HD[31:24], OP[7:0], HD[23:16], CMD_TXRX_RST, AB[7:0], AB[15:8]};
		ed = {ed, AB[23:16], OPERATION_MODE_REG_NORMAL | {2'b00, c[2], 1'b0, c[4], 3'h4} | {6'h00, c[3], 1'b0}};
		ea.push_back(DEV_OPERATION_MODE_REG);
		chk(32'(i_pbxh_dev_model.log_a.size()), 32'(ea.size()), "write count");
		foreach (ea[i])
		begin
			chk({24'h0, i_pbxh_dev_model.log_a[i]}, {24'h0, ea[i]}, "order");
			chk({24'h0, i_pbxh_dev_model.log_d[i]}, {24'h0, ed[i]}, "data");
		end
		chk(32'(i_pbxh_dev_model.log_r[3] - i_pbxh_dev_model.log_r[2] >= 1035), 1, "wait");
		chk(32'(i_pbxh_dev_model.n_stat - s0 >= 2), 1, "status polled");
	endtask
	initial
	begin
		mclk = 1'b0;
		forever
			#5 mclk = ~mclk;
	end
	// link clock is unrelated in phase to mclk
	initial
	begin
		ref_clk = 1'b0;
		#3.3;
		forever
			#62.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		#600000;
		n_fail++;
		tally_and_finish();
	end
	initial
	begin
		{resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (16)
			@(posedge mclk);
		resetn <= 1'b1;
		repeat (3)
			@(posedge mclk);
		chk(cdl, 1'b1, "collision hold in reset");
		axi_rd(8'h18);
		chk(r, 2'b10, "unmapped read");
		chk(v, 32'h0, "unmapped data");
		axi_wr(8'h1c, 32'hffff_ffff);
		chk(r, 2'b10, "unmapped write");
		axi_wr(REG_STATUS, 32'hffff_ffff);
		chk(r, 2'b00, "status write");
		cfg();
		run(32'h2211_004f);
		chk(cdl, 1'b1, "point to point");
		chk(i_pbxh_dev_model.pcm_lowz, 4'hf, "all drive");
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (4)
			@(posedge mclk);
		resetn <= 1'b1;
		repeat (3)
			@(posedge mclk);
		chk(i_pbxh_dev_model.ts_field[7], 4'hf, "field kept");
		cfg();
		run(32'h5566_00b1);
		chk(cdl, 1'b0, "bus configuration");
		chk(i_pbxh_dev_model.pcm_lowz, 4'h0, "all float");
		tally_and_finish();
	end
endmodule
